// [core/lpmc_top.sv]
`timescale 1ns/1ns
`default_nettype none
// Low-power mode controller
module lpmc_top
	import lpmc_pkg::*;
(
	// Clock and reset
	input  wire logic                   clock,
	input  wire logic                   rst,
	// CPU side
	input  wire logic                   sleep_req,     // Core executes sleep request
	input  wire lpmc_sel_t              mode_sel,
	input  wire lpmc_cfg_t              cfg,
	input  wire logic [2*LPMC_NIO-1:0]  io_pull_cfg,
	// Wake sources from pins/other domains
	input  wire lpmc_wake_t             wake_in,
	input  wire logic                   wake_pin_fall, // Wake pin polarity: 1 = falling edge
	// Autonomous peripherals
	input  wire logic [LPMC_NPER-1:0]   kern_req,
	input  wire logic [LPMC_NPER-1:0]   bus_req,
	input  wire logic [LPMC_NPER-1:0]   periph_irq,
	// Controls out
	output var  lpmc_ctl_t              ctl,
	output var  logic [2*LPMC_NIO-1:0]  io_hold,
	output var  logic                   io_hold_en,
	output var  logic                   kern_clk_on,
	output var  logic                   cpu_run,
	output var  logic                   standby_reset,
	output var  lpmc_state_t            mode
);
	import lpmc_pkg::*;

	// ------------------------------------------------------------
	// Input synchronisation
	// ------------------------------------------------------------
	localparam int NW = 7;
	logic [NW-1:0]        wake_s;      // Synchronised wake sources
	logic [LPMC_NPER-1:0] kern_s;      // Synchronised kernel requests
	logic [LPMC_NPER-1:0] bus_s;       // Synchronised bus requests
	logic [LPMC_NPER-1:0] irq_s;       // Synchronised peripheral interrupts

	lpmc_sync #(.W(NW)) u_sync_wake (
		.clock (clock),
		.rst   (rst),
		.din   (wake_in),
		.dout  (wake_s)
	);
	lpmc_sync #(.W(3*LPMC_NPER)) u_sync_per (
		.clock (clock),
		.rst   (rst),
		.din   ({kern_req, bus_req, periph_irq}),
		.dout  ({kern_s, bus_s, irq_s})
	);

	lpmc_wake_t wk;
	assign wk = lpmc_wake_t'(wake_s);

	// ------------------------------------------------------------
	// Wake pin edge with selectable polarity
	// ------------------------------------------------------------
	logic pin_d; // Previous wake pin level
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pin_d <= 1'b0;
		end else begin
			pin_d <= wk.wake_pin;
		end
	end
	wire pin_edge = wake_pin_fall ? (pin_d & ~wk.wake_pin) : (~pin_d & wk.wake_pin);

	// ------------------------------------------------------------
	// Clock request arbitration
	// ------------------------------------------------------------
	lpmc_state_t state;
	lpmc_state_t next_state;
	logic        bus_any;
	logic        kern_on;
	// Both stop flavours share clock gating and the request path
	function automatic logic stop_state(input lpmc_state_t s);
		return (s == LPMC_STOP0) || (s == LPMC_STOP1);
	endfunction
	wire         in_stop = stop_state(state);

	lpmc_clkreq u_clkreq (
		.clock       (clock),
		.rst         (rst),
		.kern_req    (kern_s),
		.bus_req     (bus_s),
		.in_stop     (in_stop),
		.kern_clk_on (kern_on),
		.bus_any     (bus_any)
	);

	// ------------------------------------------------------------
	// Wake decoding
	// ------------------------------------------------------------
	// Sleep wakes on any interrupt or event
	wire wake_sleep = wk.irq | (|irq_s);
	// Stop wakes on the always-on sources or any peripheral interrupt
	wire wake_stop  = wk.irq | (|irq_s) | wk.rtc | wk.tamper | wk.watchdog
	                | wk.ext_reset | wk.sleep_timer | pin_edge;
	// Standby: timer accepted only with radio retention
	wire wake_stby  = wk.ext_reset | wk.watchdog | pin_edge | wk.rtc | wk.tamper
	                | (cfg.radio_keep & wk.sleep_timer);

	// ------------------------------------------------------------
	// Mode sequencer
	// ------------------------------------------------------------
	lpmc_sel_t   target;   // Mode latched at entry
	logic [3:0]  settle;   // Transition settle counter
	wire         settled = (settle == LPMC_SETTLE_LAST);
	logic        bus_pend; // Bus request seen while entry settles

	always_comb begin
		next_state = state;
		case (state)
			LPMC_RUN: begin
				if (sleep_req) begin
					next_state = (mode_sel == LPMC_SEL_SLEEP) ? LPMC_SLEEP : LPMC_ENTER;
				end
			end
			LPMC_SLEEP: begin
				if (wake_sleep) begin
					next_state = LPMC_RUN;
				end
			end
			LPMC_ENTER: begin
				// Requests wait until the entry settles
				if (settled) begin
					case (target)
						LPMC_SEL_STOP0: next_state = LPMC_STOP0;
						LPMC_SEL_STOP1: next_state = LPMC_STOP1;
						default:        next_state = LPMC_STANDBY;
					endcase
				end
			end
			LPMC_STOP1: begin
				if (wake_stop) begin
					next_state = LPMC_EXIT;
				end else if (bus_any | bus_pend) begin
					next_state = LPMC_STOP0;
				end
			end
			LPMC_STOP0: begin
				if (wake_stop) begin
					next_state = LPMC_EXIT;
				end else if (!bus_any && target == LPMC_SEL_STOP1) begin
					next_state = LPMC_STOP1;
				end
			end
			LPMC_STANDBY: begin
				if (wake_stby) begin
					next_state = LPMC_EXIT;
				end
			end
			LPMC_EXIT: begin
				if (settled) begin
					next_state = LPMC_RUN;
				end
			end
			default: next_state = LPMC_RUN;
		endcase
	end

	// State and entry latch; reset always lands in Run
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state    <= LPMC_RUN;
			target   <= LPMC_SEL_SLEEP;
			settle   <= 4'h0;
			bus_pend <= 1'b0;
		end else begin
			state <= next_state;
			if (state == LPMC_RUN && sleep_req) begin
				target <= mode_sel;
			end
			settle <= (next_state != state || settled) ? 4'h0 : settle + 4'h1;
			// A request during entry is held, then served once settled
			if (state == LPMC_ENTER) begin
				bus_pend <= bus_pend | (|bus_s);
			end else if (state != LPMC_STOP1 || next_state != LPMC_STOP1) begin
				bus_pend <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Control decode
	// ------------------------------------------------------------
	wire       is_stby   = (state == LPMC_STANDBY);
	wire       stby_keep = cfg.radio_keep | (|cfg.bank_keep);
	lpmc_ctl_t next_ctl;

	always_comb begin
		next_ctl             = '0;
		next_ctl.core_clk    = (state == LPMC_RUN) || (state == LPMC_EXIT);
		next_ctl.periph_clk  = !in_stop && !is_stby;
		next_ctl.fast_rc     = !in_stop && !is_stby;
		next_ctl.crystal     = (state == LPMC_RUN) || (state == LPMC_SLEEP);
		next_ctl.pll         = (state == LPMC_RUN) || (state == LPMC_SLEEP);
		next_ctl.sys_from_rc = 1'b1;
		next_ctl.main_reg    = !is_stby && (state != LPMC_STOP1);
		next_ctl.lp_reg      = (state == LPMC_STOP1) || (is_stby && stby_keep);
		next_ctl.core_power  = !is_stby;
		next_ctl.bank_power  = is_stby ? cfg.bank_keep : 2'h3;
		next_ctl.radio_power = !is_stby || cfg.radio_keep;
		next_ctl.bod_on      = 1'b1;
		next_ctl.bod_ulp     = cfg.bod_ulp && (is_stby || state == LPMC_STOP1);
		next_ctl.dma_en      = (state != LPMC_STOP1) && !is_stby;
		next_ctl.radio_auto  = (state == LPMC_STOP0) && cfg.range1;
		if (state == LPMC_STOP0) begin
			// Autonomous bus clocks run from the RC, distributed to enabled units
			next_ctl.fast_rc    = bus_any;
			next_ctl.periph_clk = bus_any;
		end
	end

	// ------------------------------------------------------------
	// Registered outputs
	// ------------------------------------------------------------
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ctl           <= '0;
			io_hold       <= '0;
			io_hold_en    <= 1'b0;
			kern_clk_on   <= 1'b0;
			cpu_run       <= 1'b1;
			standby_reset <= 1'b0;
			mode          <= LPMC_RUN;
		end else begin
			ctl         <= next_ctl;
			kern_clk_on <= kern_on;
			cpu_run     <= next_ctl.core_clk;
			mode        <= state;
			// Pads frozen at their pull setting while core is off
			io_hold_en  <= is_stby;
			if (state == LPMC_ENTER) begin
				io_hold <= io_pull_cfg;
			end
			// Core domain lost power: exit from Standby is a reset
			standby_reset <= is_stby && wake_stby;
		end
	end
endmodule
`default_nettype wire

// [core/lpmc_pkg.sv]
package lpmc_pkg;

	// ------------------------------------------------------------
	// Mode encodings and sizes
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		LPMC_SEL_SLEEP,
		LPMC_SEL_STOP0,
		LPMC_SEL_STOP1,
		LPMC_SEL_STANDBY
	} lpmc_sel_t;

	typedef enum logic [2:0] {
		LPMC_RUN,
		LPMC_SLEEP,
		LPMC_ENTER,
		LPMC_STOP0,
		LPMC_STOP1,
		LPMC_STANDBY,
		LPMC_EXIT
	} lpmc_state_t;

	localparam int LPMC_NPER     = 7;   // Converter, 2 timers, serial, lp serial, SPI, I2C
	localparam int LPMC_NIO      = 8;   // Retained I/O pads
	localparam int LPMC_NBANK    = 2;   // SRAM banks
	localparam int LPMC_SETTLE_NS = 100; // Regulator/oscillator settle time
	localparam int LPMC_CLK_NS    = 10;
	localparam int LPMC_SETTLE_CYC = (LPMC_SETTLE_NS + LPMC_CLK_NS - 1) / LPMC_CLK_NS;
	localparam logic [3:0] LPMC_SETTLE_LAST = 4'(LPMC_SETTLE_CYC - 1);

	// I/O pull codes
	localparam logic [1:0] LPMC_IO_FLOAT = 2'h0;
	localparam logic [1:0] LPMC_IO_UP    = 2'h1;
	localparam logic [1:0] LPMC_IO_DOWN  = 2'h2;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic       radio_keep;  // Radio retention in Standby
		logic [1:0] bank_keep;   // SRAM bank retention in Standby
		logic       bod_ulp;     // Brownout ultralow in Stop 1/Standby
		logic       range1;      // Voltage range 1
	} lpmc_cfg_t;

	typedef struct packed {
		logic ext_reset;
		logic watchdog;
		logic wake_pin;
		logic rtc;
		logic tamper;
		logic sleep_timer;
		logic irq;       // Any interrupt or event
	} lpmc_wake_t;

	typedef struct packed {
		logic core_clk;
		logic periph_clk;
		logic fast_rc;
		logic crystal;
		logic pll;
		logic sys_from_rc;
		logic main_reg;
		logic lp_reg;
		logic core_power;
		logic [1:0] bank_power;
		logic radio_power;
		logic bod_on;
		logic bod_ulp;
		logic dma_en;
		logic radio_auto;
	} lpmc_ctl_t;

endpackage

// [core/lpmc_sync.sv]
`timescale 1ns/1ns
`default_nettype none
// Three-stage synchroniser; change accepted when stages two and three agree
module lpmc_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clock,
	input  wire logic         rst,
	// Data
	input  wire logic [W-1:0] din,
	output var  logic [W-1:0] dout
);
	logic [W-1:0] s1; // Metastable stage, read only by s2
	logic [W-1:0] s2;
	logic [W-1:0] s3;

	// ------------------------------------------------------------
	// Shift chain
	// ------------------------------------------------------------
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s1   <= '0;
			s2   <= '0;
			s3   <= '0;
			dout <= '0;
		end else begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
			for (int i = 0; i < W; i++) begin
				if (s2[i] == s3[i]) begin
					dout[i] <= s3[i];
				end
			end
		end
	end
endmodule
`default_nettype wire

// [core/lpmc_clkreq.sv]
`timescale 1ns/1ns
`default_nettype none
// Autonomous clock request arbitration
module lpmc_clkreq
	import lpmc_pkg::*;
(
	// Clock and reset
	input  wire logic                 clock,
	input  wire logic                 rst,
	// Requests, already synchronised
	input  wire logic [LPMC_NPER-1:0] kern_req,
	input  wire logic [LPMC_NPER-1:0] bus_req,
	input  wire logic                 in_stop,
	// Results
	output var  logic                 kern_clk_on,
	output var  logic                 bus_any
);
	// ------------------------------------------------------------
	// Kernel clock gate and bus request summary
	// ------------------------------------------------------------
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			kern_clk_on <= 1'b0;
			bus_any     <= 1'b0;
		end else begin
			kern_clk_on <= |kern_req;
			bus_any     <= in_stop & (|bus_req);
		end
	end
endmodule
`default_nettype wire

// [sim/lpmc_top_asserts.sv]
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------
// Mode controller checker
// ------------------------------------------------
module lpmc_top_asserts
	import lpmc_pkg::*;
(
	// Clock and reset
	input wire logic                 clock,
	input wire logic                 rst,
	// Watched ports
	input wire lpmc_sel_t            mode_sel,
	input wire lpmc_wake_t           wake_in,
	input wire logic [LPMC_NPER-1:0] kern_req,
	input wire logic [LPMC_NPER-1:0] bus_req,
	input wire lpmc_ctl_t            ctl,
	input wire logic                 io_hold_en,
	input wire logic                 kern_clk_on,
	input wire logic                 cpu_run,
	input wire lpmc_state_t          mode
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// Three settled cycles let the registered controls catch up with mode
	sequence s_stop;
		(mode == LPMC_STOP0 || mode == LPMC_STOP1) [*3];
	endsequence
	sequence s_stby;
		(mode == LPMC_STANDBY) [*3];
	endsequence
	stop_gate_a: assert property (s_stop |-> !ctl.core_clk && !ctl.pll && !ctl.crystal && ctl.core_power)
		else $error("core clock or fast source alive in stop");
	stop1_reg_a: assert property ((mode == LPMC_STOP1) [*3] |-> !ctl.main_reg && ctl.lp_reg)
		else $error("stop 1 regulator wrong");
	stop0_reg_a: assert property ((mode == LPMC_STOP0) [*3] |-> ctl.main_reg)
		else $error("stop 0 main regulator off");
	stby_off_a: assert property (s_stby |-> !ctl.core_power && !ctl.fast_rc && ctl.bod_on && io_hold_en)
		else $error("standby supplies wrong");
	cpu_halt_a: assert property (!cpu_run |-> mode != LPMC_RUN)
		else $error("core halted in run");
	reset_run_a: assert property ($fell(rst) |-> mode == LPMC_RUN && cpu_run)
		else $error("not in run after reset");
	kern_on_a: assert property ((kern_req != '0) [*8] |-> kern_clk_on)
		else $error("kernel clock missing");
	kern_off_a: assert property ((kern_req == '0) [*8] |-> !kern_clk_on)
		else $error("kernel clock stuck on");
	bus_promote_a: assert property ((mode == LPMC_STOP1 && bus_req != '0) [*2] |-> ##[1:12] mode != LPMC_STOP1)
		else $error("bus request did not leave stop 1");
	bus_return_a: assert property ((mode == LPMC_STOP0 && bus_req == '0 && mode_sel == LPMC_SEL_STOP1) [*3]
		|-> ##[1:12] mode != LPMC_STOP0)
		else $error("stop 0 held without request");
	rc_serve_a: assert property ((mode == LPMC_STOP0 && bus_req != '0) [*8] |-> ctl.fast_rc && ctl.dma_en)
		else $error("no fast clock for dma");
	rtc_wake_a: assert property (mode == LPMC_STANDBY && wake_in.rtc |-> ##[1:16] mode != LPMC_STANDBY)
		else $error("clock alarm did not wake");
endmodule
bind lpmc_top lpmc_top_asserts u_lpmc_top_asserts (.clock, .rst, .mode_sel, .wake_in, .kern_req, .bus_req,
	.ctl, .io_hold_en, .kern_clk_on, .cpu_run, .mode);
`default_nettype wire

// [sim/lpmc_periph_model.sv]
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------
// Autonomous peripheral model
// ------------------------------------------------
module lpmc_periph_model
	import lpmc_pkg::*;
(
	// Clock and reset
	input  wire logic                 clock,
	input  wire logic                 rst,
	// Commands from the bench
	input  wire logic                 trig,
	input  wire logic [LPMC_NPER-1:0] sel,
	input  wire logic [3:0]           lag,
	input  wire logic [7:0]           len,
	// Requests toward the controller
	output var  logic [LPMC_NPER-1:0] kern_req,
	output var  logic [LPMC_NPER-1:0] bus_req
);
	int wait_n; // Start delay, so slow peripherals can be modelled
	int run_n;  // Cycles the transfer keeps the bus
	// A hardware trigger starts the peripheral
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wait_n <= 0;
			run_n <= 0;
		end else if (trig) begin
			wait_n <= lag;
			run_n <= len;
		end else if (wait_n > 0) begin
			wait_n <= wait_n - 1;
		end else if (run_n > 0) begin
			run_n <= run_n - 1;
		end
	end
	// Both requests drop together once the transfer ends
	assign kern_req = (wait_n == 0 && run_n > 0) ? sel : '0;
	assign bus_req  = kern_req;
endmodule
`default_nettype wire

// [sim/testbench.sv]
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------
// Mode controller bench
// ------------------------------------------------
module testbench;
	import lpmc_pkg::*;
	logic                  clock, rst, sleep_req, wake_pin_fall, trig;
	lpmc_sel_t             mode_sel;
	lpmc_cfg_t             cfg;
	lpmc_wake_t            wake_in;
	logic [2*LPMC_NIO-1:0] io_pull_cfg, io_hold;
	logic [LPMC_NPER-1:0]  kern_req, bus_req, periph_irq, sel;
	logic [3:0]            lag;
	logic [7:0]            len;
	lpmc_ctl_t             ctl;
	logic                  io_hold_en, kern_clk_on, cpu_run, standby_reset;
	lpmc_state_t           mode;
	int                    n_errors, n_tests, k;
	int                    n_sreset = 0; // Standby wake resets seen so far
	logic [31:0]           rnd;
	// Reference model: mode reached for each selection, wake bit per standby case
	lpmc_state_t           tgt [4] = '{LPMC_SLEEP, LPMC_STOP0, LPMC_STOP1, LPMC_STANDBY};
	int                    src [8] = '{6, 5, 4, 3, 2, 1, 4, 1};
	lpmc_top u_lpmc_top (.clock, .rst, .sleep_req, .mode_sel, .cfg, .io_pull_cfg, .wake_in, .wake_pin_fall,
		.kern_req, .bus_req, .periph_irq, .ctl, .io_hold, .io_hold_en, .kern_clk_on, .cpu_run,
		.standby_reset, .mode);
	lpmc_periph_model u_lpmc_periph_model (.clock, .rst, .trig, .sel, .lag, .len, .kern_req, .bus_req);
	// Count every cycle of the standby wake reset; stop exits must add none
	always @(posedge clock) begin
		n_sreset <= n_sreset + int'(standby_reset === 1'b1);
	end
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] x;
		x = v ^ (v << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic test_done();
		if (n_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Poll on the falling edge so registered outputs have settled
	task automatic wait_mode(input lpmc_state_t m);
		for (k = 0; k < 60 && mode !== m; k++) @(negedge clock);
		if (mode !== m) begin
			chk(mode, m);
			test_done();
		end
	endtask
	// One-cycle sleep request; t also fires the peripheral trigger in the same cycle
	task automatic enter(input lpmc_sel_t s, input logic t);
		@(posedge clock);
		mode_sel <= s;
		sleep_req <= 1'b1;
		trig <= t;
		@(posedge clock);
		sleep_req <= 1'b0;
		trig <= 1'b0;
		wait_mode(tgt[s]);
	endtask
	initial begin
		rst = 1'b1;
		mode_sel = LPMC_SEL_SLEEP;
		{sleep_req, wake_pin_fall, trig, lag, len, cfg, io_pull_cfg, wake_in, periph_irq, sel} = '0;
		{n_errors, n_tests} = '0;
		rnd = 32'h09e3;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		@(negedge clock);
		chk({mode, cpu_run}, {LPMC_RUN, 1'b1});
		enter(LPMC_SEL_SLEEP, 1'b0);
		chk({cpu_run, ctl.periph_clk}, 2'h1);
		@(posedge clock);
		wake_in.irq <= 1'b1;
		wait_mode(LPMC_RUN);
		@(posedge clock);
		wake_in.irq <= 1'b0;
		// Prompt request after entry, then a request raised during entry
		for (int r = 0; r < 2; r++) begin
			rnd = xs(rnd);
			@(posedge clock);
			cfg <= rnd[4:0];
			sel <= rnd[12:6] | 7'h1;
			lag <= r ? 4'h3 : 4'h0;
			len <= 8'h28;
			enter(LPMC_SEL_STOP1, r[0]);
			if (r == 0) begin
				chk({ctl.main_reg, ctl.lp_reg, ctl.bod_ulp, ctl.core_clk}, {2'h1, cfg.bod_ulp, 1'b0});
				@(posedge clock);
				trig <= 1'b1;
				@(posedge clock);
				trig <= 1'b0;
			end
			wait_mode(LPMC_STOP0);
			repeat (4) @(negedge clock);
			chk({ctl.fast_rc, ctl.periph_clk, ctl.sys_from_rc, ctl.main_reg, ctl.dma_en, kern_clk_on,
				ctl.radio_auto}, {6'h3f, cfg.range1});
			wait_mode(LPMC_STOP1);
			repeat (3) @(negedge clock);
			chk({kern_clk_on, ctl.fast_rc}, 2'h0);
			@(posedge clock);
			periph_irq <= sel;
			wait_mode(LPMC_RUN);
			chk({ctl.sys_from_rc, ctl.fast_rc}, 2'h3);
			@(posedge clock);
			periph_irq <= '0;
		end
		enter(LPMC_SEL_STOP0, 1'b0);
		chk({ctl.main_reg, ctl.core_clk, ctl.pll, ctl.core_power}, 4'h9);
		@(posedge clock);
		periph_irq <= 7'h40;
		wait_mode(LPMC_RUN);
		@(posedge clock);
		periph_irq <= '0;
		// Every standby wake source; the last case has no radio retention
		for (int i = 0; i < 8; i++) begin
			rnd = xs(rnd);
			@(posedge clock);
			cfg <= {i == 5, rnd[1:0], rnd[2], rnd[3]};
			io_pull_cfg <= rnd[31:16] & ~{rnd[30:16] & 15'h5555, 1'b0};
			wake_pin_fall <= (i == 6);
			wake_in.wake_pin <= (i == 6);
			enter(LPMC_SEL_STANDBY, 1'b0);
			chk({ctl.core_power, ctl.bank_power, ctl.radio_power, ctl.bod_on, ctl.bod_ulp, io_hold, io_hold_en},
				{1'b0, cfg.bank_keep, cfg.radio_keep, 1'b1, cfg.bod_ulp, io_pull_cfg, 1'b1});
			@(posedge clock);
			wake_in <= wake_in ^ (7'h1 << src[i]);
			if (i == 7) begin
				repeat (30) @(negedge clock);
				chk(mode, LPMC_STANDBY);
				@(posedge clock);
				wake_in.rtc <= 1'b1;
			end
			wait_mode(LPMC_RUN);
			chk({ctl.sys_from_rc, ctl.fast_rc}, 2'h3);
			chk(n_sreset, i + 1);
			@(posedge clock);
			wake_in <= '0;
		end
		test_done();
	end
endmodule
`default_nettype wire
